// ### bench/rsc_board_model.sv
// Board-side strap model: resistors, a floating security strap, spare pull-downs.
`timescale 1ns/1ps
module rsc_board_model (
  input  wire logic       clk_sys,
  input  wire logic       strap_pullup_en,
  input  wire logic [3:0] plat_code,
  input  wire logic [2:0] core_code,
  input  wire logic       sec_val,
  input  wire logic       sec_float,
  input  wire logic       arb_val,
  output logic [3:0]      plat_pins,
  output logic            bus_ctl_pin,
  output logic            addr_latch_pin,
  output logic            gp_line2_pin,
  output logic            sec_pin,
  output logic            arb_pin,
  output logic [3:0]      spare_pins
);
  logic [2:0] hold_q;  // Cycles a floating net keeps its pulled-up charge.
  logic       wobble_q;  // Changes every cycle once the charge has gone.

  // The weak pull-up only holds the net while enabled; after that it decays.
  always_ff @(posedge clk_sys) begin
    if (strap_pullup_en) begin
      hold_q   <= 3'h4;
      wobble_q <= 1'b0;
    end else begin
      if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end
      wobble_q <= !wobble_q;
    end
  end

  // The reference clock is not modelled: each code is assumed paired with one
  // that meets the memory rate, minimum speeds and the PCI clock need.
  // No pull-downs on reset-request, trigger, source-id or sleep pins.
  // A low security strap is only used with a platform of 400 MHz or less.

  assign plat_pins = plat_code;
  assign {bus_ctl_pin, addr_latch_pin, gp_line2_pin} = core_code;
  // Floating strap reads high through the pull-up, then wanders.
  assign sec_pin = !sec_float ? sec_val : (hold_q != 3'h0) ? 1'b1 : wobble_q;
  assign arb_pin = arb_val;
  assign spare_pins = 4'h0;
endmodule  // rsc_board_model

// ### bench/tb.sv
// Self-checking testbench of the strap ratio decoder.
`timescale 1ns/1ps
module tb;
  import rsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] plat = 4'h0;
  logic [2:0] core = 3'h0;
  logic secv = 1'b1, sec_fl = 1'b0, arb = 1'b0;
  logic [3:0] p_pins, sp_pins;
  logic bc_pin, al_pin, gp_pin, sec_pin, arb_pin;
  logic strap_pullup_en, reset_driven_oe, pci_addr_oe;
  logic [7:0] plat_ratio_q, core_ratio_half_q, sec_div_q, mem_div_q;
  logic plat_code_err_q, core_code_err_q, straps_valid_q;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failures = 0, cmp_count = 0;

  always #5 clk_sys = !clk_sys;

  rsc_board_model board (.clk_sys(clk_sys), .strap_pullup_en(strap_pullup_en),
    .plat_code(plat), .core_code(core), .sec_val(secv), .sec_float(sec_fl), .arb_val(arb),
    .plat_pins(p_pins), .bus_ctl_pin(bc_pin), .addr_latch_pin(al_pin),
    .gp_line2_pin(gp_pin), .sec_pin(sec_pin), .arb_pin(arb_pin), .spare_pins(sp_pins));

  rsc_strap_decode dut (.clk_sys(clk_sys), .rst_n(rst_n), .platform_ratio_straps(p_pins),
    .bus_ctl_strap(bc_pin), .addr_latch_strap(al_pin), .gp_line2_strap(gp_pin),
    .sec_ratio_strap(sec_pin), .pci_arbiter_strap(arb_pin), .spare_cfg_straps(sp_pins),
    .strap_pullup_en(strap_pullup_en), .reset_driven_oe(reset_driven_oe),
    .pci_addr_oe(pci_addr_oe), .plat_ratio_q(plat_ratio_q),
    .core_ratio_half_q(core_ratio_half_q), .sec_div_q(sec_div_q), .mem_div_q(mem_div_q),
    .plat_code_err_q(plat_code_err_q), .core_code_err_q(core_code_err_q),
    .straps_valid_q(straps_valid_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected platform multiplier; zero marks a reserved code.
  function automatic logic [7:0] plat_mult(input logic [3:0] c);
    case (c)
      4'h0: return 8'h10;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC: return {4'h0, c};
      default: return 8'h00;
    endcase
  endfunction

  // Expected core ratio in halves; zero marks a reserved code.
  function automatic logic [7:0] core_half(input logic [2:0] c);
    if (c == 3'h0) return 8'h08;
    return (c == 3'h1 || c == 3'h2) ? 8'h00 : {5'h00, c};
  endfunction

  // Six-cycle reset with straps already set, then a bounded wait for capture.
  task automatic do_reset();
    int n;
    n = 0;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(strap_pullup_en, 32'h1);
    chk(reset_driven_oe, 32'h1);
    rst_n <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (straps_valid_q !== 1'b1 && n < 20);
    chk(n < 20, 32'h1);
    chk(strap_pullup_en, 32'h0);
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    r = bresp;
    if (bvalid !== 1'b1) failures++;
    bready <= 1'b0;
  endtask

  // One read; data taken at the edge that sees rvalid.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    if (rvalid !== 1'b1) failures++;
    rready <= 1'b0;
  endtask

  // Every platform and core code, both security settings.
  task automatic t_sweep();
    for (int i = 0; i < 16; i++) begin
      plat <= 4'(i);
      core <= 3'(i);
      secv <= i[0];
      do_reset();
      chk(plat_ratio_q, plat_mult(4'(i)));
      chk(plat_code_err_q, plat_mult(4'(i)) == 8'h00);
      chk(core_ratio_half_q, core_half(3'(i)));
      chk(core_code_err_q, core_half(3'(i)) == 8'h00);
      chk(sec_div_q, i[0] ? 32'h3 : 32'h2);
      chk(mem_div_q, RSC_MEM_DIV);
    end
  endtask

  // Floating security strap, then strap changes after capture must not show.
  task automatic t_float_hold();
    logic [31:0] d;
    logic [1:0] r;
    plat <= 4'h5;
    core <= 3'h6;
    secv <= 1'b0;
    sec_fl <= 1'b1;
    do_reset();
    chk(sec_div_q, 32'h3);
    plat <= 4'h9;
    core <= 3'h3;
    sec_fl <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(plat_ratio_q, 32'h5);
    chk(core_ratio_half_q, 32'h6);
    axi_rd(RSC_OFS_RATIO, d, r);
    chk(d, {8'h00, RSC_SEC_DIV3, 8'h06, 8'h05});
  endtask

  // Arbiter strap drives the address pins even with the disable register set to one.
  task automatic t_arbiter();
    logic [31:0] d;
    logic [1:0] r;
    arb <= 1'b1;
    do_reset();
    axi_rd(RSC_OFS_DEVDIS, d, r);
    chk(d, RSC_RST_DEVDIS);
    axi_wr(RSC_OFS_DEVDIS, 32'h1, r);
    chk(r, RSC_RESP_OKAY);
    axi_rd(RSC_OFS_DEVDIS, d, r);
    chk(d, 32'h1);
    chk(pci_addr_oe, 32'h1);
    axi_rd(RSC_OFS_RAW, d, r);
    chk(d, 32'h0002_1039);
    axi_rd(8'h40, d, r);
    chk(r, RSC_RESP_SLVERR);
    chk(d, 32'h0);
    arb <= 1'b0;
    do_reset();
    chk(pci_addr_oe, 32'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    t_sweep();
    t_float_hold();
    t_arbiter();
    report_and_stop();
  end

  // Watchdog: the whole run needs a few microseconds.
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule  // tb

// ### logic/rsc_axil_slave.sv
// AXI4-Lite register slave for the strap ratio decoder.
`timescale 1ns/1ps
module rsc_axil_slave
  import rsc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] rd_status,
  input  wire logic [31:0] rd_ratio,
  input  wire logic [31:0] rd_raw,
  input  wire logic [31:0] rd_id,
  output logic [31:0]      devdis_q
);

  logic        aw_have_q, aw_have_d;    // Write address held.
  logic [7:0]  aw_addr_q, aw_addr_d;    // Held write address.
  logic        w_have_q,  w_have_d;     // Write data held.
  logic [31:0] w_data_q,  w_data_d;     // Held write data.
  logic [3:0]  w_strb_q,  w_strb_d;     // Held byte strobes.
  logic        bvalid_q,  bvalid_d;     // Write response pending.
  logic [1:0]  bresp_q,   bresp_d;      // Write response code.
  logic        rvalid_q,  rvalid_d;     // Read response pending.
  logic [31:0] rdata_q,   rdata_d;      // Read data.
  logic [1:0]  rresp_q,   rresp_d;      // Read response code.
  logic [31:0] devdis_d;                // Next disable register.

  // Address and data are taken independently, each once per write.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Next state of both channels; write commits once both halves are held.
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    devdis_d  = devdis_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RSC_RESP_SLVERR;
      if (aw_addr_q == RSC_OFS_DEVDIS) begin
        bresp_d = RSC_RESP_OKAY;
        for (int i = 0; i < 4; i++) begin
          if (w_strb_q[i]) begin
            devdis_d[i*8 +: 8] = w_data_q[i*8 +: 8];
          end
        end
      end else if (aw_addr_q == RSC_OFS_STATUS || aw_addr_q == RSC_OFS_RATIO ||
                   aw_addr_q == RSC_OFS_RAW || aw_addr_q == RSC_OFS_ID) begin
        // Read-only registers ignore the data but answer okay.
        bresp_d = RSC_RESP_OKAY;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RSC_RESP_OKAY;
      case (s_axi_araddr)
        RSC_OFS_STATUS: rdata_d = rd_status;
        RSC_OFS_RATIO:  rdata_d = rd_ratio;
        RSC_OFS_RAW:    rdata_d = rd_raw;
        RSC_OFS_DEVDIS: rdata_d = devdis_q;
        RSC_OFS_ID:     rdata_d = rd_id;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RSC_RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers of the slave.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RSC_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RSC_RESP_OKAY;
      devdis_q  <= RSC_RST_DEVDIS;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      devdis_q  <= devdis_d;
    end
  end

  chk_read_answers: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered next cycle.");

endmodule : rsc_axil_slave

// ### logic/rsc_pkg.sv
// Package of constants, encodings and register map for the strap ratio decoder.
// Operation
// - Sample four platform straps, decode platform ratio.
// - Decode bus-ctl, addr-latch, gp-line2 into core ratio.
// - Security strap 0 gives 2:1, 1 gives 3:1.
// - Undriven security strap defaults to 3:1.
// - Memory bus clock is half platform clock.
// - Weak pull-ups enabled only during reset.
// - Unresistored strap pairs read 2'b11 in reset.
// - Marked outputs are driven during reset.
// - Arbiter strap drives PCI address despite disable.
package rsc_pkg;

  // Register byte offsets.
  localparam logic [7:0] RSC_OFS_STATUS = 8'h00;
  localparam logic [7:0] RSC_OFS_RATIO  = 8'h04;
  localparam logic [7:0] RSC_OFS_RAW    = 8'h08;
  localparam logic [7:0] RSC_OFS_DEVDIS = 8'h0C;
  localparam logic [7:0] RSC_OFS_ID     = 8'h10;

  // Field positions in the ratio register.
  localparam int RSC_FLD_PLAT = 0;
  localparam int RSC_FLD_CORE = 8;
  localparam int RSC_FLD_SEC  = 16;

  // Field positions in the status register.
  localparam int RSC_FLD_DONE     = 0;
  localparam int RSC_FLD_PLAT_ERR = 1;
  localparam int RSC_FLD_CORE_ERR = 2;

  // Field positions in the raw strap register.
  localparam int RSC_FLD_RAW_PLAT  = 0;
  localparam int RSC_FLD_RAW_CORE  = 4;
  localparam int RSC_FLD_RAW_SEC   = 7;
  localparam int RSC_FLD_RAW_ARB   = 12;
  localparam int RSC_FLD_RAW_SPARE = 8;

  // Device disable bit that turns the PCI block off.
  localparam int RSC_FLD_PCI_DIS = 0;

  // Reset values.
  localparam logic [31:0] RSC_RST_DEVDIS = 32'h0000_0000;
  localparam logic [7:0]  RSC_RST_RATIO  = 8'h00;

  // Platform ratio codes, named by the multiplier; code zero selects 16.
  localparam logic [3:0] RSC_PLAT_16 = 4'h0;
  localparam logic [3:0] RSC_PLAT_3  = 4'h3;
  localparam logic [3:0] RSC_PLAT_4  = 4'h4;
  localparam logic [3:0] RSC_PLAT_5  = 4'h5;
  localparam logic [3:0] RSC_PLAT_6  = 4'h6;
  localparam logic [3:0] RSC_PLAT_8  = 4'h8;
  localparam logic [3:0] RSC_PLAT_9  = 4'h9;
  localparam logic [3:0] RSC_PLAT_10 = 4'hA;
  localparam logic [3:0] RSC_PLAT_12 = 4'hC;

  // Core ratio codes; decoded value is the ratio in halves (4:1 is 8).
  localparam logic [2:0] RSC_CORE_4_1 = 3'h0;
  localparam logic [2:0] RSC_CORE_3_2 = 3'h3;
  localparam logic [2:0] RSC_CORE_2_1 = 3'h4;
  localparam logic [2:0] RSC_CORE_5_2 = 3'h5;
  localparam logic [2:0] RSC_CORE_3_1 = 3'h6;
  localparam logic [2:0] RSC_CORE_7_2 = 3'h7;

  // Security engine divider values.
  localparam logic [7:0] RSC_SEC_DIV2 = 8'h02;
  localparam logic [7:0] RSC_SEC_DIV3 = 8'h03;

  // Memory bus clock divider relative to the platform clock.
  localparam logic [7:0] RSC_MEM_DIV = 8'h02;

  // AXI responses.
  localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

  // Capture sequencer states.
  typedef enum logic [1:0] {
    RSC_ST_RESET = 2'b00,
    RSC_ST_SYNC  = 2'b01,
    RSC_ST_HOLD  = 2'b10
  } rsc_state_type;

  // Cycles spent filling the pin synchronisers before the capture.
  localparam logic [1:0] RSC_SYNC_CYCLES = 2'h2;

endpackage : rsc_pkg

// ### logic/rsc_strap_decode.sv
// Top of the strap sampler and clock ratio decoder.
`timescale 1ns/1ps
module rsc_strap_decode
  import rsc_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_5A01  // Arbitrary identity value.
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  platform_ratio_straps,
  input  wire logic        bus_ctl_strap,
  input  wire logic        addr_latch_strap,
  input  wire logic        gp_line2_strap,
  input  wire logic        sec_ratio_strap,
  input  wire logic        pci_arbiter_strap,
  input  wire logic [3:0]  spare_cfg_straps,
  output logic             strap_pullup_en,
  output logic             reset_driven_oe,
  output logic             pci_addr_oe,
  output logic [7:0]       plat_ratio_q,
  output logic [7:0]       core_ratio_half_q,
  output logic [7:0]       sec_div_q,
  output logic [7:0]       mem_div_q,
  output logic             plat_code_err_q,
  output logic             core_code_err_q,
  output logic             straps_valid_q,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions.

  // Platform multiplier from the four-bit code; zero marks a reserved code.
  function automatic logic [7:0] plat_decode(input logic [3:0] code);
    case (code)
      RSC_PLAT_16: plat_decode = 8'h10;
      RSC_PLAT_3:  plat_decode = 8'h03;
      RSC_PLAT_4:  plat_decode = 8'h04;
      RSC_PLAT_5:  plat_decode = 8'h05;
      RSC_PLAT_6:  plat_decode = 8'h06;
      RSC_PLAT_8:  plat_decode = 8'h08;
      RSC_PLAT_9:  plat_decode = 8'h09;
      RSC_PLAT_10: plat_decode = 8'h0A;
      RSC_PLAT_12: plat_decode = 8'h0C;
      default:     plat_decode = 8'h00;
    endcase
  endfunction

  // Core ratio in halves; zero marks codes 001 and 010.
  function automatic logic [7:0] core_decode(input logic [2:0] code);
    case (code)
      RSC_CORE_4_1: core_decode = 8'h08;
      RSC_CORE_3_2: core_decode = 8'h03;
      RSC_CORE_2_1: core_decode = 8'h04;
      RSC_CORE_5_2: core_decode = 8'h05;
      RSC_CORE_3_1: core_decode = 8'h06;
      RSC_CORE_7_2: core_decode = 8'h07;
      default:      core_decode = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: every strap pin passes two flip-flops.

  localparam int NPIN = 13;                    // Strap pins in all.
  logic [NPIN-1:0] pins;                        // Raw pin vector.
  logic [NPIN-1:0] sync1_q;                     // First stage, read by stage two only.
  logic [NPIN-1:0] sync2_q;                     // Stable strap levels.

  assign pins = {pci_arbiter_strap, spare_cfg_straps, sec_ratio_strap,
                 bus_ctl_strap, addr_latch_strap, gp_line2_strap,
                 platform_ratio_straps};

  // The pins are held in reset by the pull-ups; the synchroniser flops are held
  // in reset too, both stages at the pulled-up level of all ones.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= {NPIN{1'b1}};
      sync2_q <= {NPIN{1'b1}};
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture sequencer: waits for the synchronisers to fill, latches once.

  rsc_state_type state_q, state_d;    // Sequencer state.
  logic [1:0]    wait_q, wait_d;      // Synchroniser fill count.
  logic [NPIN-1:0] raw_q, raw_d;      // Latched strap levels.
  logic [7:0]    plat_d, core_d, sec_d, mem_d; // Next decoded values.
  logic          perr_d, cerr_d, valid_d;      // Next status bits.
  logic          capture;             // Capture strobe.

  assign capture = (state_q == RSC_ST_SYNC) && (wait_q == RSC_SYNC_CYCLES);

  // Next-state logic; the capture happens exactly once per reset.
  always_comb begin
    state_d = state_q;
    wait_d  = wait_q;
    raw_d   = raw_q;
    plat_d  = plat_ratio_q;
    core_d  = core_ratio_half_q;
    sec_d   = sec_div_q;
    mem_d   = mem_div_q;
    perr_d  = plat_code_err_q;
    cerr_d  = core_code_err_q;
    valid_d = straps_valid_q;
    case (state_q)
      RSC_ST_RESET: begin
        state_d = RSC_ST_SYNC;
        wait_d  = 2'h1;
      end
      RSC_ST_SYNC: begin
        if (capture) begin
          state_d = RSC_ST_HOLD;
          raw_d   = sync2_q;
          plat_d  = plat_decode(sync2_q[3:0]);
          perr_d  = (plat_decode(sync2_q[3:0]) == 8'h00);
          // Core strap order: bus-ctl, addr-latch, gp-line2.
          core_d  = core_decode(sync2_q[6:4]);
          cerr_d  = (core_decode(sync2_q[6:4]) == 8'h00);
          // A floating strap reads one through the pull-up, so 3:1 is default.
          sec_d   = sync2_q[7] ? RSC_SEC_DIV3 : RSC_SEC_DIV2;
          mem_d   = RSC_MEM_DIV;
          valid_d = 1'b1;
        end else begin
          wait_d = wait_q + 2'h1;
        end
      end
      RSC_ST_HOLD: begin
        state_d = RSC_ST_HOLD;
      end
      default: begin
        state_d = RSC_ST_RESET;
      end
    endcase
  end

  // Sequencer and result registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q           <= RSC_ST_RESET;
      wait_q            <= 2'h0;
      raw_q             <= {NPIN{1'b1}};
      plat_ratio_q      <= RSC_RST_RATIO;
      core_ratio_half_q <= RSC_RST_RATIO;
      sec_div_q         <= RSC_SEC_DIV3;
      mem_div_q         <= RSC_MEM_DIV;
      plat_code_err_q   <= 1'b0;
      core_code_err_q   <= 1'b0;
      straps_valid_q    <= 1'b0;
    end else begin
      state_q           <= state_d;
      wait_q            <= wait_d;
      raw_q             <= raw_d;
      plat_ratio_q      <= plat_d;
      core_ratio_half_q <= core_d;
      sec_div_q         <= sec_d;
      mem_div_q         <= mem_d;
      plat_code_err_q   <= perr_d;
      core_code_err_q   <= cerr_d;
      straps_valid_q    <= valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad controls.

  logic [31:0] devdis;   // Device disable register from the slave.

  // Pull-ups only while reset is applied: rst_n low enables them.
  assign strap_pullup_en = !rst_n;
  // Marked outputs keep their enables in reset instead of floating.
  assign reset_driven_oe = 1'b1;
  // The latched arbiter strap decides once straps_valid_q is set; the disable bit does not gate it,
  // which can cause bus contention if the board strapped it wrongly.
  assign pci_addr_oe = straps_valid_q && raw_q[RSC_FLD_RAW_ARB];

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [31:0] rd_status, rd_ratio, rd_raw;   // Read views.

  assign rd_status = {29'h0, core_code_err_q, plat_code_err_q, straps_valid_q};
  assign rd_ratio  = {8'h00, sec_div_q, core_ratio_half_q, plat_ratio_q};
  assign rd_raw    = {14'h0, devdis[RSC_FLD_PCI_DIS], 4'h0, raw_q};

  rsc_axil_slave u_slave (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_status     (rd_status),
    .rd_ratio      (rd_ratio),
    .rd_raw        (rd_raw),
    .rd_id         (ID_VALUE),
    .devdis_q      (devdis)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_plat_ratio_16: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capture && sync2_q[3:0] == 4'h0 |=> plat_ratio_q == 8'h10)
    else $error("Platform code 0000 did not give 16.");

  chk_plat_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capture && sync2_q[3:0] == 4'h7 |=> plat_code_err_q && plat_ratio_q == 8'h00)
    else $error("Reserved platform code not flagged.");

  chk_core_ratio_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capture && sync2_q[6:4] == 3'h3 |=> core_ratio_half_q == 8'h03 && !core_code_err_q)
    else $error("Core code 011 did not give 3:2.");

  chk_sec_ratio: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capture |=> sec_div_q == ($past(sync2_q[7]) ? 8'h03 : 8'h02))
    else $error("Security divider mismatches strap.");

  chk_sec_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !straps_valid_q |-> sec_div_q == 8'h03)
    else $error("Security divider default not 3.");

  chk_mem_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
    straps_valid_q |-> mem_div_q == 8'h02)
    else $error("Memory divider not two.");

  chk_pullup_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !strap_pullup_en)
    else $error("Pull-up enabled outside reset.");

  chk_capture_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state_q == RSC_ST_SYNC) |-> ##1 capture ##1 straps_valid_q)
    else $error("Capture not on the third cycle.");

  chk_hold_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    straps_valid_q |=> $stable(plat_ratio_q) && $stable(core_ratio_half_q)
      && $stable(sec_div_q) && straps_valid_q)
    else $error("Ratios changed after capture.");

  chk_pci_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    straps_valid_q && raw_q[RSC_FLD_RAW_ARB] |-> pci_addr_oe)
    else $error("Arbiter strap did not drive address pins.");

  chk_driven_reset: assert property (@(posedge clk_sys) reset_driven_oe)
    else $error("Marked output released.");

  cov_capture:    cover property (@(posedge clk_sys) disable iff (!rst_n) capture);
  cov_sec_fast:   cover property (@(posedge clk_sys) disable iff (!rst_n)
    straps_valid_q && sec_div_q == 8'h02);
  cov_plat_err:   cover property (@(posedge clk_sys) disable iff (!rst_n) plat_code_err_q);
  cov_devdis_pci: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pci_addr_oe && devdis[RSC_FLD_PCI_DIS]);

endmodule : rsc_strap_decode
